// ==== src/sgd_pkg.sv ====
// Constants for the scatter-gather DMA register set.
package sgd_pkg;
   localparam int NENG = 4;
   // Engines 0,1 are host_to_card, engines 2,3 are card_to_host.
   localparam logic [31:0] CH_PAGES   = 32'h21200100;
   localparam logic [15:0] COMMON_ADR = 16'h4000;
   localparam int NUSR = 5;
   localparam logic [39:0] USR_PAGES  = 40'h9190828180;
   // Register offsets within a channel.
   localparam logic [7:0] OFS_CTRL  = 8'h04;
   localparam logic [7:0] OFS_NDP   = 8'h08;
   localparam logic [7:0] OFS_SDP   = 8'h0c;
   localparam logic [7:0] OFS_BYTES = 8'h1c;
   // Engine control and status bits.
   localparam int CTL_IEN  = 0;
   localparam int CTL_IACT = 1;
   localparam int CTL_EN   = 8;
   localparam int CTL_RUN  = 10;
   localparam int CTL_WAIT = 11;
   localparam int CTL_RREQ = 14;
   localparam int CTL_RST  = 15;
   // Sticky flag indices, flag k sits at control bit k+1.
   localparam int NFLG  = 5;
   localparam int F_ACT = 0;
   localparam int F_IOC = 1;
   localparam int F_ALN = 2;
   localparam int F_FET = 3;
   localparam int F_ABT = 4;
   localparam int PTR_LSB = 5;
   localparam int PTR_W   = 27;
   localparam logic [PTR_W-1:0] PTR_STEP = 27'h1;
   localparam logic [PTR_LSB-1:0] PTR_PAD = 5'h00;
   localparam int CNT_LSB = 2;
   // Common register bits.
   localparam int CM_GIE  = 0;
   localparam int CM_IACT = 1;
   localparam int CM_PEND = 2;
   localparam int CM_MODE = 3;
   localparam int CM_UIE  = 4;
   localparam int CM_UACT = 5;
   localparam int CM_H2C  = 16;
   localparam int CM_C2H  = 24;
   localparam int NH2C    = 2;
   // Byte count sampling interval.
   localparam longint SAMPLE_NS = 1000000000;
   localparam longint CLK_NS    = 4;
   localparam int unsigned SAMPLE_CYCLES = int'(SAMPLE_NS / CLK_NS);
   localparam int TICK_W = 28;
endpackage

// ==== src/sgd_flag.sv ====
// Sticky write-one-to-clear status flag.
`timescale 1ns/1ps
module sgd_flag (
   // Clock and reset
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   // Control
   input  wire logic i_set,
   input  wire logic i_clr,
   output logic      o_q
);
   typedef struct packed {
      logic q;
   } sgd_flag_s;

   sgd_flag_s st;
   sgd_flag_s next_st;

   // A hardware event in the clear cycle is kept, so no event is lost.
   always_comb begin
      next_st = st;
      if (i_set) begin
         next_st.q = 1'b1;
      end else if (i_clr) begin
         next_st.q = 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_q = st.q;
endmodule

// ==== src/sgd_rate.sv ====
// Per-second transferred byte counter with sample counter.
`timescale 1ns/1ps
module sgd_rate #(
   parameter int unsigned PERIOD = sgd_pkg::SAMPLE_CYCLES
) (
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // Byte stream
   input  wire logic        i_valid,
   input  wire logic [15:0] i_bytes,
   output logic [31:0]      o_count
);
   typedef struct packed {
      logic [sgd_pkg::TICK_W-1:0] tick;
      logic [31:0]                acc;
      logic [29:0]                last;
      logic [1:0]                 samp;
   } sgd_rate_s;

   sgd_rate_s   st;
   sgd_rate_s   next_st;
   logic [31:0] add;

   // The acc wraps silently; one second at full rate can exceed it.
   always_comb begin
      next_st = st;
      add = i_valid ? {16'h0000, i_bytes} : 32'h0000_0000;
      next_st.acc = st.acc + add;
      next_st.tick = st.tick + 1'b1;
      if (st.tick == sgd_pkg::TICK_W'(PERIOD - 1)) begin
         next_st.tick = '0;
         next_st.last = next_st.acc[31:sgd_pkg::CNT_LSB];
         next_st.samp = st.samp + 2'h1;
         next_st.acc  = 32'h0000_0000;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_count = {st.last, st.samp};
endmodule

// ==== src/sgd_top.sv ====
// Register set of a four-engine descriptor DMA with common interrupt control.
`timescale 1ns/1ps
module sgd_top #(
   parameter int unsigned SAMPLE_CYCLES = sgd_pkg::SAMPLE_CYCLES
) (
   // Clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   // Host register access
   input  wire logic             i_wr,
   input  wire logic             i_rd,
   input  wire logic [15:0]      i_addr,
   input  wire logic [31:0]      i_wdata,
   output logic [31:0]           o_rdata,
   output logic                  o_rvalid,
   // Data mover side, one lane per engine
   input  wire logic [3:0]       i_desc_done,
   input  wire logic [3:0]       i_desc_ioc,
   input  wire logic [3:0]       i_align_err,
   input  wire logic [3:0]       i_fetch_err,
   input  wire logic [3:0]       i_xfer_valid,
   input  wire logic [3:0][15:0] i_xfer_bytes,
   output logic [3:0]            o_running,
   output logic [3:0][31:0]      o_desc_addr,
   // User logic handshake and interrupts
   input  wire logic [3:0]       i_user_ack,
   input  wire logic             i_user_irq,
   input  wire logic             i_intx_mode,
   output logic [3:0]            o_user_rst_req,
   output logic [3:0]            o_user_rst,
   output logic                  o_irq,
   // User register windows
   output logic                  o_usr_wr,
   output logic                  o_usr_rd,
   output logic [2:0]            o_usr_win,
   output logic [7:0]            o_usr_addr,
   output logic [31:0]           o_usr_wdata,
   input  wire logic [31:0]      i_usr_rdata
);
   typedef struct packed {
      logic [3:0]                          ien;
      logic [3:0]                          en;
      logic [3:0]                          rreq;
      logic [3:0]                          rst;
      logic [3:0]                          run;
      logic [3:0]                          idle;
      logic [3:0][sgd_pkg::PTR_W-1:0]      ndp;
      logic [3:0][sgd_pkg::PTR_W-1:0]      sdp;
      logic                                gie;
      logic                                uie;
      logic                                irq;
      logic                                rd1;
      logic                                rd_usr;
      logic [31:0]                         rbuf;
      logic                                rvalid;
      logic [31:0]                         rdata;
      logic                                usr_wr;
      logic                                usr_rd;
      logic [2:0]                          usr_win;
      logic [7:0]                          usr_addr;
      logic [31:0]                         usr_wdata;
   } sgd_top_s;

   sgd_top_s                st;
   sgd_top_s                next_st;
   logic [3:0][4:0]         flg;
   logic [3:0][4:0]         fset;
   logic [3:0][4:0]         fclr;
   logic [3:0][31:0]        cnt;
   logic [3:0]              eng_irq;
   logic                    uact;
   logic                    uclr;
   logic                    pend;
   logic                    com_hit;
   logic [7:0]              page;
   logic [7:0]              ofs;

   // ------------------------------------------------------------------
   // Sticky flags and byte counters
   // ------------------------------------------------------------------
   assign page    = i_addr[15:8];
   assign ofs     = i_addr[7:0];
   assign com_hit = (i_addr == sgd_pkg::COMMON_ADR);

   for (genvar e = 0; e < sgd_pkg::NENG; e++) begin : g_eng
      logic hit;
      logic wctl;
      assign hit  = (page == sgd_pkg::CH_PAGES[e*8 +: 8]);
      assign wctl = i_wr && hit && (ofs == sgd_pkg::OFS_CTRL);
      assign fset[e][sgd_pkg::F_IOC] = i_desc_ioc[e];
      assign fset[e][sgd_pkg::F_ALN] = i_align_err[e];
      assign fset[e][sgd_pkg::F_FET] = i_fetch_err[e];
      // Abort is a reset request or reset issued while moving data.
      assign fset[e][sgd_pkg::F_ABT] = wctl && st.run[e]
         && (i_wdata[sgd_pkg::CTL_RREQ] || i_wdata[sgd_pkg::CTL_RST]);
      assign fset[e][sgd_pkg::F_ACT] = |fset[e][sgd_pkg::NFLG-1:1];
      for (genvar k = 0; k < sgd_pkg::NFLG; k++) begin : g_flg
         // Bits written as one clear, as does an engine reset; zeros leave flags alone.
         assign fclr[e][k] = (wctl && i_wdata[k+1]) || st.rst[e];
         sgd_flag u_flag (
            .i_mclk  (i_mclk),
            .i_rst_n (i_rst_n),
            .i_set   (fset[e][k]),
            .i_clr   (fclr[e][k]),
            .o_q     (flg[e][k])
         );
      end
      sgd_rate #(
         .PERIOD (SAMPLE_CYCLES)
      ) u_rate (
         .i_mclk  (i_mclk),
         .i_rst_n (i_rst_n),
         .i_valid (i_xfer_valid[e]),
         .i_bytes (i_xfer_bytes[e]),
         .o_count (cnt[e])
      );
      assign eng_irq[e] = st.ien[e] && flg[e][sgd_pkg::F_ACT];
   end

   assign uclr = i_wr && com_hit && i_wdata[sgd_pkg::CM_UACT];
   sgd_flag u_uact (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_set   (i_user_irq),
      .i_clr   (uclr),
      .o_q     (uact)
   );
   assign pend = (|eng_irq) || (st.uie && uact);

   // ------------------------------------------------------------------
   // Register update and read selection
   // ------------------------------------------------------------------
   always_comb begin
      logic [31:0] rsel;
      logic        usr_hit;
      rsel = 32'h0000_0000;
      usr_hit = 1'b0;
      next_st = st;
      next_st.usr_wr = 1'b0;
      next_st.usr_rd = 1'b0;
      for (int e = 0; e < sgd_pkg::NENG; e++) begin
         next_st.rst[e] = 1'b0;
         if (st.rst[e]) begin
            next_st.en[e]   = 1'b0;
            next_st.rreq[e] = 1'b0;
            next_st.ndp[e]  = '0;
         end else if (st.run[e] && i_desc_done[e]) begin
            next_st.ndp[e] = st.ndp[e] + sgd_pkg::PTR_STEP;
         end
         if (i_user_ack[e]) begin
            next_st.rreq[e] = 1'b0;
         end
         if (i_align_err[e]) begin
            next_st.en[e] = 1'b0;
         end
         if (i_wr && page == sgd_pkg::CH_PAGES[e*8 +: 8]) begin
            case (ofs)
               sgd_pkg::OFS_CTRL: begin
                  next_st.ien[e] = i_wdata[sgd_pkg::CTL_IEN];
                  next_st.en[e]  = i_wdata[sgd_pkg::CTL_EN];
                  next_st.rst[e] = i_wdata[sgd_pkg::CTL_RST];
                  if (i_wdata[sgd_pkg::CTL_RREQ]) begin
                     next_st.rreq[e] = 1'b1;
                  end
               end
               sgd_pkg::OFS_NDP: begin
                  if (!st.en[e]) begin
                     next_st.ndp[e] = i_wdata[31:sgd_pkg::PTR_LSB];
                  end
               end
               sgd_pkg::OFS_SDP: begin
                  next_st.sdp[e] = i_wdata[31:sgd_pkg::PTR_LSB];
               end
               default: begin
               end
            endcase
         end
         // Work exists only before the host owned descriptor.
         next_st.run[e]  = next_st.en[e] && (next_st.ndp[e] != next_st.sdp[e]);
         next_st.idle[e] = next_st.en[e] && (next_st.ndp[e] == next_st.sdp[e]);
         if (page == sgd_pkg::CH_PAGES[e*8 +: 8]) begin
            case (ofs)
               sgd_pkg::OFS_CTRL: begin
                  rsel[sgd_pkg::CTL_IEN] = st.ien[e];
                  for (int k = 0; k < sgd_pkg::NFLG; k++) begin
                     rsel[sgd_pkg::CTL_IACT + k] = flg[e][k];
                  end
                  rsel[sgd_pkg::CTL_EN]   = st.en[e];
                  rsel[sgd_pkg::CTL_RUN]  = st.run[e];
                  rsel[sgd_pkg::CTL_WAIT] = st.idle[e];
                  rsel[sgd_pkg::CTL_RREQ] = st.rreq[e];
                  rsel[sgd_pkg::CTL_RST]  = st.rst[e];
               end
               sgd_pkg::OFS_NDP: begin
                  rsel = {st.ndp[e], sgd_pkg::PTR_PAD};
               end
               sgd_pkg::OFS_SDP: begin
                  rsel = {st.sdp[e], sgd_pkg::PTR_PAD};
               end
               sgd_pkg::OFS_BYTES: begin
                  rsel = cnt[e];
               end
               default: begin
                  rsel = 32'h0000_0000;
               end
            endcase
         end
      end
      if (com_hit) begin
         if (i_wr) begin
            next_st.gie = i_wdata[sgd_pkg::CM_GIE];
            next_st.uie = i_wdata[sgd_pkg::CM_UIE];
         end
         rsel[sgd_pkg::CM_GIE]  = st.gie;
         rsel[sgd_pkg::CM_IACT] = st.gie && pend;
         rsel[sgd_pkg::CM_PEND] = pend;
         rsel[sgd_pkg::CM_MODE] = i_intx_mode;
         rsel[sgd_pkg::CM_UIE]  = st.uie;
         rsel[sgd_pkg::CM_UACT] = uact;
         // Absent engine slots above the fitted ones stay zero.
         for (int e = 0; e < sgd_pkg::NH2C; e++) begin
            rsel[sgd_pkg::CM_H2C + e] = eng_irq[e];
            rsel[sgd_pkg::CM_C2H + e] = eng_irq[sgd_pkg::NH2C + e];
         end
      end
      for (int u = 0; u < sgd_pkg::NUSR; u++) begin
         if (page == sgd_pkg::USR_PAGES[u*8 +: 8]) begin
            usr_hit = 1'b1;
            next_st.usr_win   = 3'(u);
            next_st.usr_addr  = ofs;
            next_st.usr_wdata = i_wdata;
            next_st.usr_wr    = i_wr;
            next_st.usr_rd    = i_rd;
         end
      end
      next_st.irq    = st.gie && pend;
      next_st.rd1    = i_rd;
      next_st.rd_usr = usr_hit;
      next_st.rbuf   = rsel;
      next_st.rvalid = st.rd1;
      // User data is taken in the cycle of the forwarded strobe; the word holds until the next read.
      if (st.rd1) begin
         next_st.rdata = st.rd_usr ? i_usr_rdata : st.rbuf;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign o_rdata        = st.rdata;
   assign o_rvalid       = st.rvalid;
   assign o_running      = st.run;
   assign o_user_rst_req = st.rreq;
   assign o_user_rst     = st.rst;
   assign o_irq          = st.irq;
   assign o_usr_wr       = st.usr_wr;
   assign o_usr_rd       = st.usr_rd;
   assign o_usr_win      = st.usr_win;
   assign o_usr_addr     = st.usr_addr;
   assign o_usr_wdata    = st.usr_wdata;
   for (genvar e = 0; e < sgd_pkg::NENG; e++) begin : g_out
      assign o_desc_addr[e] = {st.ndp[e], sgd_pkg::PTR_PAD};
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   property p_ndp_lock;
      @(posedge i_mclk) disable iff (!i_rst_n)
      st.en[2] && !i_desc_done[2] && !st.rst[2] |=> $stable(st.ndp[2]);
   endproperty
   a_ndp_lock: assert property (p_ndp_lock) else $error("pointer moved while enabled");

   property p_ndp_write;
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_wr && i_addr == 16'h2108 && !st.en[3] && !st.rst[3]
         |=> st.ndp[3] == $past(i_wdata[31:5]);
   endproperty
   a_ndp_write: assert property (p_ndp_write) else $error("pointer write lost");

   property p_ptr_pad;
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_rd && i_addr == 16'h010c |-> ##2 o_rvalid && o_rdata[4:0] == 5'h00;
   endproperty
   a_ptr_pad: assert property (p_ptr_pad) else $error("pointer low bits not zero");

   property p_ioc_flag;
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_desc_ioc[0] |=> flg[0][1] && flg[0][0];
   endproperty
   a_ioc_flag: assert property (p_ioc_flag) else $error("completion flag not set");

   property p_w1c_zero;
      @(posedge i_mclk) disable iff (!i_rst_n)
      flg[1][3] && i_wr && i_addr == 16'h0104 && !i_wdata[4] && !st.rst[1] |=> flg[1][3];
   endproperty
   a_w1c_zero: assert property (p_w1c_zero) else $error("flag lost on zero write");

   property p_run_gap;
      @(posedge i_mclk) disable iff (!i_rst_n)
      o_running[0] |-> st.en[0] && st.ndp[0] != st.sdp[0] && !st.idle[0];
   endproperty
   a_run_gap: assert property (p_run_gap) else $error("running at owned descriptor");

   property p_user_rst;
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_wr && i_addr == 16'h2004 && i_wdata[15] |=> o_user_rst[2] ##1 !o_user_rst[2] && !st.en[2];
   endproperty
   a_user_rst: assert property (p_user_rst) else $error("reset pulse wrong");

   property p_ack_clr;
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_user_ack[1] && !(i_wr && i_addr == 16'h0104 && i_wdata[14]) |=> !o_user_rst_req[1];
   endproperty
   a_ack_clr: assert property (p_ack_clr) else $error("reset request not cleared");

   property p_irq_gate;
      @(posedge i_mclk) disable iff (!i_rst_n)
      ##1 o_irq == ($past(st.gie) && $past(pend));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");

   c_irq: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_irq));
   c_run: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_running[0] ##[1:20] st.idle[0]);
   c_usr: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_usr_rd ##1 o_rvalid);
endmodule

// ==== test/sgd_far.sv ====
// Far-side model: user logic that answers reset requests and user register reads.
`timescale 1ns/1ps
module sgd_far (
   // Clock
   input  wire logic       i_mclk,
   // From the register set
   input  wire logic [3:0] i_rst_req,
   input  wire logic       i_rd,
   input  wire logic [2:0] i_win,
   input  wire logic [7:0] i_addr,
   // To the register set
   output logic [3:0]      o_ack,
   output logic [31:0]     o_rdata
);
   logic [31:0] last;
   int          cnt [4];
   // Outside a read the bus shows the inverse of the last word, so stale data never matches.
   assign o_rdata = i_rd ? {8'h5a, 5'h00, i_win, 8'h00, i_addr} : ~last;
   initial begin
      o_ack = 4'h0;
      last = 32'h0;
      cnt = '{0, 0, 0, 0};
   end
   always @(posedge i_mclk) begin
      if (i_rd) begin
         last <= o_rdata;
      end
   end
   // Each request gets a one-cycle acknowledge after a delay that differs per engine.
   always @(negedge i_mclk) begin
      for (int e = 0; e < 4; e++) begin
         o_ack[e] = 1'b0;
         cnt[e] = i_rst_req[e] ? cnt[e] + 1 : 0;
         if (cnt[e] == 3 + e) begin
            o_ack[e] = 1'b1;
         end
      end
   end
endmodule

// ==== test/scatter_gather_dma_registers_bench.sv ====
// Self-checking bench comparing the DMA register set with a reference model.
`timescale 1ns/1ps
module scatter_gather_dma_registers_bench;
   localparam logic [31:0] M        = 32'hffffffe0;
   localparam logic [15:0] BASE [4] = '{16'h0000, 16'h0100, 16'h2000, 16'h2100};
   localparam logic [7:0]  USR [5]  = '{8'h80, 8'h81, 8'h82, 8'h90, 8'h91};
   logic             i_mclk, i_rst_n, i_wr, i_rd, i_user_irq, i_intx_mode;
   logic             o_rvalid, o_irq, o_usr_wr, o_usr_rd;
   logic [15:0]      i_addr, b;
   logic [31:0]      i_wdata, o_rdata, i_usr_rdata, o_usr_wdata, p;
   logic [3:0]       i_desc_done, i_desc_ioc, i_align_err, i_fetch_err, i_xfer_valid;
   logic [3:0]       i_user_ack, o_running, o_user_rst_req, o_user_rst, m_en, m_ien, m_rq;
   logic [3:0][15:0] i_xfer_bytes;
   logic [3:0][31:0] o_desc_addr;
   logic [2:0]       o_usr_win;
   logic [7:0]       o_usr_addr;
   logic [31:0]      m_ndp [4], m_sdp [4];
   logic [4:0]       m_f [4];
   logic             m_gie, m_uie, m_ua;
   int               num_errors, compares, cycles, rst_cnt [4];
   int               seed = 76502;
   int               m_tick, m_acc [4], m_bc [4];
   logic [3:0]       i_user_irq_vec;

   sgd_top #(.SAMPLE_CYCLES(16)) sgd_top_i (.i_mclk, .i_rst_n, .i_wr, .i_rd, .i_addr, .i_wdata,
      .o_rdata, .o_rvalid, .i_desc_done, .i_desc_ioc, .i_align_err, .i_fetch_err,
      .i_xfer_valid, .i_xfer_bytes, .o_running, .o_desc_addr, .i_user_ack, .i_user_irq,
      .i_intx_mode, .o_user_rst_req, .o_user_rst, .o_irq, .o_usr_wr, .o_usr_rd, .o_usr_win,
      .o_usr_addr, .o_usr_wdata, .i_usr_rdata);
   sgd_far sgd_far_i (.i_mclk, .i_rst_req(o_user_rst_req), .i_rd(o_usr_rd), .i_win(o_usr_win),
      .i_addr(o_usr_addr), .o_ack(i_user_ack), .o_rdata(i_usr_rdata));

   initial begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      cycles++;
      for (int e = 0; e < 4; e++) begin
         rst_cnt[e] += (o_user_rst[e] === 1'b1) ? 1 : 0;
      end
      // Byte count model: one sample every 16 cycles, counted from reset release.
      if (i_rst_n) begin
         m_tick++;
         for (int e = 0; e < 4; e++) begin
            m_acc[e] += i_xfer_valid[e] ? int'(i_xfer_bytes[e]) : 0;
            if (m_tick == 16) begin
               m_bc[e] = ((m_acc[e] >> 2) << 2) | ((m_bc[e] + 1) & 3);
               m_acc[e] = 0;
            end
         end
         m_tick = (m_tick == 16) ? 0 : m_tick;
      end
      if (cycles == 5000) begin
         num_errors++;
         results();
      end
   end
   always @(negedge i_mclk) begin
      i_xfer_valid = 4'($random(seed));
      i_xfer_bytes = {$random(seed), $random(seed)};
   end

   // ----------------------------------------------------------------------------------
   // Bus tasks, model and comparison
   // ----------------------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      @(negedge i_mclk);
      i_wr = 1'b1;
      i_addr = a;
      i_wdata = v;
      @(negedge i_mclk);
      i_wr = 1'b0;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
      @(negedge i_mclk);
      i_rd = 1'b1;
      i_addr = a;
      @(negedge i_mclk);
      i_rd = 1'b0;
      @(posedge i_mclk);
      #1;
      chk({31'h0, o_rvalid}, 32'h1, "read answer");
      chk(o_rdata, exp, "read data");
   endtask
   task automatic pulse(ref logic [3:0] sig, input int e, input int n);
      @(negedge i_mclk);
      sig[e] = 1'b1;
      repeat (n) @(negedge i_mclk);
      sig[e] = 1'b0;
   endtask
   function automatic logic [31:0] ectl(input int e);
      logic run;
      run = m_en[e] && (m_ndp[e] != m_sdp[e]);
      return {17'h0, m_rq[e], 2'h0, m_en[e] && !run, run, 1'b0, m_en[e], 2'h0, m_f[e], m_ien[e]};
   endfunction
   function automatic logic [31:0] ecm();
      logic [3:0] st;
      logic       pend;
      for (int e = 0; e < 4; e++) begin
         st[e] = m_ien[e] & m_f[e][0];
      end
      pend = (|st) | (m_uie & m_ua);
      return {6'h0, st[3:2], 6'h0, st[1:0], 10'h0, m_ua, m_uie, i_intx_mode, pend & m_gie & 1'b0 | pend,
              pend & m_gie, m_gie};
   endfunction
   task automatic results();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------------------
   initial begin
      {i_rst_n, i_wr, i_rd, i_user_irq_vec, i_addr, i_wdata} = '0;
      {i_desc_done, i_desc_ioc, i_align_err, i_fetch_err, m_en, m_ien, m_rq} = '0;
      {m_gie, m_uie, m_ua} = '0;
      i_intx_mode = 1'($random(seed));
      repeat (10) @(posedge i_mclk);
      @(negedge i_mclk);
      i_rst_n = 1'b1;
      for (int e = 0; e < 4; e++) begin
         b = BASE[e];
         m_f[e] = 5'h00;
         rdc(b + 16'h04, 32'h0);
         p = $random(seed);
         m_ndp[e] = p & M;
         m_sdp[e] = (p + 32'h60) & M;
         wr(b + 16'h08, p);
         wr(b + 16'h0c, p + 32'h60);
         rdc(b + 16'h08, m_ndp[e]);
         rdc(b + 16'h0c, m_sdp[e]);
         wr(b + 16'h04, 32'h101);
         {m_en[e], m_ien[e]} = 2'b11;
         chk({31'h0, o_running[e]}, 32'h1, "running");
         wr(b + 16'h08, ~p);
         rdc(b + 16'h04, ectl(e));
         i_desc_ioc[e] = 1'b1;
         pulse(i_desc_done, e, 4);
         i_desc_ioc[e] = 1'b0;
         m_ndp[e] += 32'h60;
         m_f[e] = 5'h03;
         chk(o_desc_addr[e], m_ndp[e], "descriptor address");
         chk({31'h0, o_running[e]}, 32'h0, "running at owned");
         rdc(b + 16'h04, ectl(e));
         rdc(16'h4000, ecm());
         wr(16'h4000, 32'h1);
         m_gie = 1'b1;
         rdc(16'h4000, ecm());
         chk({31'h0, o_irq}, 32'h1, "interrupt out");
         wr(16'h4000, 32'h0);
         m_gie = 1'b0;
         wr(b + 16'h04, 32'h101);
         rdc(b + 16'h04, ectl(e));
         wr(b + 16'h04, 32'h105);
         m_f[e] = 5'h01;
         rdc(b + 16'h04, ectl(e));
         pulse(i_fetch_err, e, 1);
         pulse(i_align_err, e, 1);
         m_f[e] = 5'h0d;
         m_en[e] = 1'b0;
         rdc(b + 16'h04, ectl(e));
         wr(b + 16'h04, 32'h1);
         rdc(b + 16'h04, ectl(e));
         wr(b + 16'h04, 32'h3f);
         m_f[e] = 5'h00;
         m_sdp[e] = m_ndp[e] + 32'h20;
         wr(b + 16'h0c, m_sdp[e]);
         wr(b + 16'h04, 32'h101);
         wr(b + 16'h04, 32'h4101);
         m_en[e] = 1'b1;
         m_f[e] = 5'h11;
         @(posedge i_mclk);
         #1;
         chk({31'h0, o_user_rst_req[e]}, 32'h1, "reset request");
         for (int k = 0; k < 20 && o_user_rst_req[e] === 1'b1; k++) begin
            @(posedge i_mclk);
            #1;
         end
         rdc(b + 16'h04, ectl(e));
         wr(b + 16'h04, 32'h8101);
         {m_en[e], m_rq[e]} = 2'b00;
         m_f[e] = 5'h00;
         m_ndp[e] = 32'h0;
         repeat (2) @(posedge i_mclk);
         rdc(b + 16'h04, ectl(e));
         rdc(b + 16'h08, 32'h0);
         chk(32'(rst_cnt[e]), 32'h1, "user reset pulses");
         $display("engine %0d test done", e);
      end
      wr(16'h4000, 32'h11);
      {m_gie, m_uie} = 2'b11;
      pulse(i_user_irq_vec, 0, 1);
      m_ua = 1'b1;
      wr(16'h4000, 32'h11);
      rdc(16'h4000, ecm());
      chk({31'h0, o_irq}, 32'h1, "user interrupt out");
      wr(16'h4000, 32'h31);
      m_ua = 1'b0;
      rdc(16'h4000, ecm());
      $display("common test done");
      for (int w = 0; w < 5; w++) begin
         p = $random(seed);
         rdc({USR[w], p[7:0]}, {8'h5a, 5'h00, 3'(w), 8'h00, p[7:0]});
         wr({USR[w], p[15:8]}, p);
         chk({28'h0, o_usr_wr, o_usr_win}, {28'h0, 1'b1, 3'(w)}, "user write strobe");
         chk({24'h0, o_usr_addr}, {24'h0, p[15:8]}, "user write offset");
         chk(o_usr_wdata, p, "user write data");
      end
      rdc(16'h3000, 32'h0);
      rdc(16'h8300, 32'h0);
      // Read early in a sample interval so the count cannot move during the read.
      for (int e = 0; e < 4; e++) begin
         while (m_tick != 2) @(negedge i_mclk);
         rdc(BASE[e] + 16'h1c, 32'(m_bc[e]));
      end
      $display("window test done");
      results();
   end
   assign i_user_irq = i_user_irq_vec[0];
endmodule
